// ==== core/spmc_consts.svh ====
// constants for the spi master/slave core
`ifndef SPMC_CONSTS_SVH
`define SPMC_CONSTS_SVH
`define SPMC_BITS 8
`define SPMC_CNT_W 3
`define SPMC_LAST_BIT 3'h7
`define SPMC_DIV_W 7
`define SPMC_RESET_BYTE 8'h00
`define SPMC_CLK_NS 4
`define SPMC_SYNC_W 3
`endif

// ==== core/spmc_pkg.sv ====
// types for the spi master/slave core
package spmc_pkg;
    typedef enum logic [1:0] {
        SPMC_IDLE = 2'b00,
        SPMC_LEAD = 2'b01,
        SPMC_TRAIL = 2'b10
    } spmc_state_t;
    typedef logic [7:0] spmc_byte_t;
endpackage

// ==== core/spmc_sync.sv ====
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`include "spmc_consts.svh"
module spmc_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic async_in,
    input wire logic reset_level,
    output logic level_q
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    // s1 only feeds s2 to keep metastability away from the compare
    // stages reset to the pin's idle level so no false edge follows reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_q <= reset_level;
            s2_q <= reset_level;
            s3_q <= reset_level;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            level_q <= reset_level;
        end else if (s2_q == s3_q) begin
            level_q <= s2_q;
        end
    end
endmodule

// ==== core/spmc_core.sv ====
// spi master/slave byte engine with pin direction control
`timescale 1ns/1ps
`include "spmc_consts.svh"
// Functional notes
// - one 8-bit shift register shifts out and in together
// - data write loads shifter in normal mode, transmit buffer in buffered mode
// - data read gives first receive buffer normally, second when buffered
// - master makes sck itself; slave synchronises incoming sck and samples it
// - master lowers slave select then clocks; both preload outgoing bytes
// - mosi carries master to slave, miso slave to master, full duplex
// - enabled: slave forces mosi, sck, ss inputs; master forces miso input
// - user-directed pins output block values when set as outputs
// - slave drives miso only while ss low when miso set as output
// - master data write starts clock generator and eight-bit transfer
// - master sets transfer done flag after shifting out a byte
// - prescaler with double bit gives seven rates, fastest clk/2
// - bit order select picks lsb or msb first
// - ignore bit makes master disregard ss, no multimaster detection
// - runs while debugging, halts while cpu is halted
// - master with ss input low drops to slave and sets flag
// - normal-mode master data write during transfer sets write collision flag; slave writes never set it
// - slave ss high resets transfer at once, partial byte lost
module spmc_core (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable_bit,
    input wire logic master_set,
    input wire logic master_clear_req,
    input wire logic [1:0] rate_divider_field,
    input wire logic rate_double_bit,
    input wire logic bit_order_select,
    input wire logic buffering_on_bit,
    input wire logic select_pin_ignore_bit,
    input wire logic debug_halt,
    input wire logic data_wr,
    input wire logic [7:0] data_wdata,
    input wire logic flag_clear,
    input wire logic [3:0] port_dir_out,
    input wire logic mosi_in,
    input wire logic miso_in,
    input wire logic sck_in,
    input wire logic ss_in,
    output logic master_q,
    output logic [7:0] data_rdata_q,
    output logic transfer_done_flag_q,
    output logic write_collision_flag_q,
    output logic busy_q,
    output logic mosi_out_q,
    output logic mosi_oe_q,
    output logic miso_out_q,
    output logic miso_oe_q,
    output logic sck_out_q,
    output logic sck_oe_q,
    output logic ss_out_q,
    output logic ss_oe_q
);
    spmc_pkg::spmc_state_t state_q;
    spmc_pkg::spmc_byte_t shift_q;
    spmc_pkg::spmc_byte_t txbuf_q;
    spmc_pkg::spmc_byte_t rx1_q;
    spmc_pkg::spmc_byte_t rx2_q;
    logic txbuf_full_q;
    logic [`SPMC_CNT_W-1:0] bit_cnt_q;
    logic [`SPMC_DIV_W-1:0] div_cnt_q;
    logic sck_s;
    logic ss_s;
    logic mosi_s;
    logic miso_s;
    logic sck_prev_q;
    logic ss_prev_q;
    logic run;
    logic sample_in;

    // pin inputs pass three flops and take a new level once the last two stages agree
    spmc_sync u_sck (.clk(clk), .rst_n(rst_n), .async_in(sck_in),
        .reset_level(1'b0), .level_q(sck_s));
    spmc_sync u_ss (.clk(clk), .rst_n(rst_n), .async_in(ss_in),
        .reset_level(1'b1), .level_q(ss_s));
    spmc_sync u_mosi (.clk(clk), .rst_n(rst_n), .async_in(mosi_in),
        .reset_level(1'b0), .level_q(mosi_s));
    spmc_sync u_miso (.clk(clk), .rst_n(rst_n), .async_in(miso_in),
        .reset_level(1'b0), .level_q(miso_s));

    // half-period in clk cycles: 1,2,4,8,16,32 then 128 (seven rates)
    function automatic logic [`SPMC_DIV_W-1:0] half_period(input logic [1:0] sel,
                                                           input logic dbl);
        logic [3:0] sh;
        // the slowest setting ignores the double bit, leaving seven rates
        sh = {1'b0, sel, 1'b0} + 4'h1 - {3'h0, dbl && (sel != 2'h3)};
        half_period = 7'h01 << sh[2:0];
        half_period = half_period - 7'h01;
    endfunction

    // next outgoing bit for the chosen bit order
    function automatic logic out_bit(input spmc_pkg::spmc_byte_t v, input logic lsb);
        out_bit = lsb ? v[0] : v[7];
    endfunction

    assign run = enable_bit && !debug_halt;

    logic ss_fall;
    logic sck_rise;
    logic sck_fall;
    logic mm_lost;
    logic slave_sel;
    logic div_hit;
    assign ss_fall = ss_prev_q && !ss_s;
    assign sck_rise = !sck_prev_q && sck_s;
    assign sck_fall = sck_prev_q && !sck_s;
    assign slave_sel = !ss_s;
    // multimaster loss only when ss is an input and not ignored
    assign mm_lost = run && master_q && !select_pin_ignore_bit
                     && !port_dir_out[3] && !ss_s;
    assign div_hit = (div_cnt_q == half_period(rate_divider_field, rate_double_bit));
    assign sample_in = master_q ? (state_q == spmc_pkg::SPMC_LEAD && div_hit)
                                : (slave_sel && sck_rise);
    // select drops on the start edge so it leads the first sck rise
    logic start_req;
    assign start_req = run && master_q && !mm_lost && state_q == spmc_pkg::SPMC_IDLE
                       && data_wr && !busy_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sck_prev_q <= 1'b0;
            ss_prev_q <= 1'b1;
        end else begin
            sck_prev_q <= sck_s;
            ss_prev_q <= ss_s;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            master_q <= 1'b0;
        end else if (mm_lost || master_clear_req) begin
            master_q <= 1'b0;
        end else if (master_set) begin
            master_q <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_cnt_q <= 7'h00;
        end else if (!master_q || state_q == spmc_pkg::SPMC_IDLE || div_hit || !run) begin
            div_cnt_q <= 7'h00;
        end else begin
            div_cnt_q <= div_cnt_q + 7'h01;
        end
    end

    // transfer engine: sck low in lead half, high in trail half (sample on rise)
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= spmc_pkg::SPMC_IDLE;
            shift_q <= `SPMC_RESET_BYTE;
            txbuf_q <= `SPMC_RESET_BYTE;
            txbuf_full_q <= 1'b0;
            bit_cnt_q <= 3'h0;
            rx1_q <= `SPMC_RESET_BYTE;
            rx2_q <= `SPMC_RESET_BYTE;
            sck_out_q <= 1'b0;
            busy_q <= 1'b0;
        end else if (!enable_bit || mm_lost || (!master_q && ss_s)) begin
            state_q <= spmc_pkg::SPMC_IDLE;
            bit_cnt_q <= 3'h0;
            sck_out_q <= 1'b0;
            busy_q <= 1'b0;
            if (data_wr && !buffering_on_bit) begin
                shift_q <= data_wdata;
            end
        end else if (run) begin
            if (data_wr) begin
                if (buffering_on_bit) begin
                    txbuf_q <= data_wdata;
                    txbuf_full_q <= 1'b1;
                end else if (!busy_q) begin
                    shift_q <= data_wdata;
                end
            end
            if (master_q && state_q == spmc_pkg::SPMC_IDLE && data_wr
                && (!busy_q || buffering_on_bit)) begin
                state_q <= spmc_pkg::SPMC_LEAD;
                busy_q <= 1'b1;
            end else if (!master_q && state_q == spmc_pkg::SPMC_IDLE && slave_sel) begin
                state_q <= spmc_pkg::SPMC_LEAD;
            end
            if (sample_in) begin
                // one bit out and one in at once, direction by bit order
                if (bit_order_select) begin
                    shift_q <= {master_q ? miso_s : mosi_s, shift_q[7:1]};
                end else begin
                    shift_q <= {shift_q[6:0], master_q ? miso_s : mosi_s};
                end
                bit_cnt_q <= bit_cnt_q + 3'h1;
                if (master_q) begin
                    sck_out_q <= 1'b1;
                    state_q <= spmc_pkg::SPMC_TRAIL;
                end
                if (bit_cnt_q == `SPMC_LAST_BIT) begin
                    rx1_q <= bit_order_select ? {master_q ? miso_s : mosi_s, shift_q[7:1]}
                                              : {shift_q[6:0], master_q ? miso_s : mosi_s};
                    rx2_q <= rx1_q;
                end
            end else if (master_q && state_q == spmc_pkg::SPMC_TRAIL && div_hit) begin
                sck_out_q <= 1'b0;
                if (bit_cnt_q == 3'h0) begin
                    if (buffering_on_bit && txbuf_full_q) begin
                        shift_q <= txbuf_q;
                        txbuf_full_q <= 1'b0;
                        state_q <= spmc_pkg::SPMC_LEAD;
                    end else begin
                        state_q <= spmc_pkg::SPMC_IDLE;
                        busy_q <= 1'b0;
                    end
                end else begin
                    state_q <= spmc_pkg::SPMC_LEAD;
                end
            end
        end
    end

    logic byte_done;
    assign byte_done = run && sample_in && bit_cnt_q == `SPMC_LAST_BIT;

    // hardware set wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            transfer_done_flag_q <= 1'b0;
        end else if (byte_done || mm_lost) begin
            transfer_done_flag_q <= 1'b1;
        end else if (flag_clear) begin
            transfer_done_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            write_collision_flag_q <= 1'b0;
        end else if (run && data_wr && !buffering_on_bit && busy_q) begin
            write_collision_flag_q <= 1'b1;
        end else if (flag_clear) begin
            write_collision_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            data_rdata_q <= `SPMC_RESET_BYTE;
        end else begin
            data_rdata_q <= buffering_on_bit ? rx2_q : rx1_q;
        end
    end

    // port_dir_out bits: 0 mosi, 1 miso, 2 sck, 3 ss
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mosi_out_q <= 1'b0;
            mosi_oe_q <= 1'b0;
            miso_out_q <= 1'b0;
            miso_oe_q <= 1'b0;
            sck_oe_q <= 1'b0;
            ss_out_q <= 1'b1;
            ss_oe_q <= 1'b0;
        end else begin
            mosi_out_q <= out_bit(shift_q, bit_order_select);
            miso_out_q <= out_bit(shift_q, bit_order_select);
            ss_out_q <= !(busy_q || start_req);
            if (!enable_bit) begin
                mosi_oe_q <= port_dir_out[0];
                miso_oe_q <= port_dir_out[1];
                sck_oe_q <= port_dir_out[2];
                ss_oe_q <= port_dir_out[3];
            end else if (master_q) begin
                mosi_oe_q <= port_dir_out[0];
                miso_oe_q <= 1'b0;
                sck_oe_q <= port_dir_out[2];
                ss_oe_q <= port_dir_out[3];
            end else begin
                mosi_oe_q <= 1'b0;
                miso_oe_q <= port_dir_out[1] && slave_sel;
                sck_oe_q <= 1'b0;
                ss_oe_q <= 1'b0;
            end
        end
    end
endmodule

// ==== bench/spmc_core_properties.sv ====
// concurrent checks on the spi core pins and flags
`timescale 1ns/1ps
module spmc_core_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable_bit,
    input wire logic master_clear_req,
    input wire logic debug_halt,
    input wire logic data_wr,
    input wire logic buffering_on_bit,
    input wire logic select_pin_ignore_bit,
    input wire logic flag_clear,
    input wire logic [3:0] port_dir_out,
    input wire logic ss_in,
    input wire logic master_q,
    input wire logic busy_q,
    input wire logic transfer_done_flag_q,
    input wire logic write_collision_flag_q,
    input wire logic sck_out_q,
    input wire logic mosi_oe_q,
    input wire logic miso_oe_q,
    input wire logic sck_oe_q,
    input wire logic ss_oe_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic on_m;
    logic on_s;
    assign on_m = enable_bit && master_q;
    assign on_s = enable_bit && !master_q;
    property p_miso_in; on_m && $past(on_m) |-> !miso_oe_q; endproperty
    property p_slave_in; on_s && $past(on_s) |-> !(mosi_oe_q || sck_oe_q || ss_oe_q); endproperty
    // ss passes a synchroniser, so six cycles of high level are asked for
    property p_miso_off; (on_s && ss_in) [*6] |-> !miso_oe_q; endproperty
    property p_start; data_wr && on_m && !busy_q && !debug_halt |=> busy_q; endproperty
    property p_wcol;
        data_wr && enable_bit && busy_q && !buffering_on_bit && !debug_halt
            |=> write_collision_flag_q;
    endproperty
    property p_done; $fell(busy_q) |-> ##[0:2] transfer_done_flag_q; endproperty
    property p_sticky; transfer_done_flag_q && !flag_clear |=> transfer_done_flag_q; endproperty
    property p_halt; $past(debug_halt) |-> $stable(sck_out_q); endproperty
    property p_mm;
        (on_m && !select_pin_ignore_bit && !port_dir_out[3] && !ss_in) [*6] |=> !master_q;
    endproperty
    property p_ssd; on_m && select_pin_ignore_bit && !master_clear_req |=> master_q; endproperty
    a_miso_in: assert property (p_miso_in) else $error("miso driven in master");
    a_slave_in: assert property (p_slave_in) else $error("slave drives input pin");
    a_miso_off: assert property (p_miso_off) else $error("miso not tristated");
    a_start: assert property (p_start) else $error("write did not start");
    a_wcol: assert property (p_wcol) else $error("collision not flagged");
    a_done: assert property (p_done) else $error("done flag missing");
    a_sticky: assert property (p_sticky) else $error("done flag dropped");
    a_halt: assert property (p_halt) else $error("sck moved while halted");
    a_mm: assert property (p_mm) else $error("master kept despite ss low");
    a_ssd: assert property (p_ssd) else $error("ignored ss cleared master");
    c_master: cover property (on_m && $fell(busy_q));
    c_wcol: cover property ($rose(write_collision_flag_q));
    c_slave: cover property (on_s && $rose(transfer_done_flag_q));
endmodule
bind spmc_core spmc_core_chk u_chk (.clk, .rst_n, .enable_bit, .master_clear_req, .debug_halt,
    .data_wr, .buffering_on_bit, .select_pin_ignore_bit, .flag_clear, .port_dir_out, .ss_in,
    .master_q, .busy_q, .transfer_done_flag_q, .write_collision_flag_q, .sck_out_q,
    .mosi_oe_q, .miso_oe_q, .sck_oe_q, .ss_oe_q);

// ==== bench/spmc_slave_model.sv ====
// behavioural spi slave, mode 0, facing the core in master mode
`timescale 1ns/1ps
module spmc_slave_model (
    input wire logic sck,
    input wire logic ss_n,
    input wire logic mosi,
    input wire logic lsb_first,
    input wire logic [7:0] tx,
    output logic miso,
    output logic [7:0] rx
);
    logic [7:0] sh;
    initial miso = 1'h0;
    always @(negedge ss_n) begin
        sh = tx;
        miso = lsb_first ? tx[0] : tx[7];
    end
    // released line shows the inverse so a stale value cannot pass
    always @(posedge ss_n) miso = ~miso;
    // the core relaunches mosi one clk after the sck rise, so a sample just after the edge still sees the bit
    always @(posedge sck) begin
        #1;
        if (!ss_n) rx = lsb_first ? {mosi, rx[7:1]} : {rx[6:0], mosi};
    end
    always @(negedge sck) if (!ss_n) begin
        sh = lsb_first ? sh >> 1 : sh << 1;
        miso = lsb_first ? sh[0] : sh[7];
    end
endmodule

// ==== bench/testbench.sv ====
// self-checking bench for the spi core in master and slave mode
`timescale 1ns/1ps
module testbench;
    logic clk = 1'h0, rst_n = 1'h0, enable_bit = 1'h0, master_set = 1'h0;
    logic master_clear_req = 1'h0, rate_double_bit = 1'h0, bit_order_select = 1'h0;
    logic buffering_on_bit = 1'h0, select_pin_ignore_bit = 1'h0, debug_halt = 1'h0;
    logic data_wr = 1'h0, flag_clear = 1'h0, mosi_in = 1'h0, sck_in = 1'h0, ss_in = 1'h1;
    logic [1:0] rate_divider_field = 2'h0;
    logic [3:0] port_dir_out = 4'hF;
    logic [7:0] data_wdata = 8'h00, slv_tx = 8'h3C, data_rdata_q, slv_rx;
    logic master_q, transfer_done_flag_q, write_collision_flag_q, busy_q, mosi_out_q;
    logic mosi_oe_q, miso_out_q, miso_oe_q, sck_out_q, sck_oe_q, ss_out_q, ss_oe_q, miso_in;
    int mismatches = 0, total_checks = 0;
    spmc_core u_dut (.clk, .rst_n, .enable_bit, .master_set, .master_clear_req,
        .rate_divider_field, .rate_double_bit, .bit_order_select, .buffering_on_bit,
        .select_pin_ignore_bit, .debug_halt, .data_wr, .data_wdata, .flag_clear, .port_dir_out,
        .mosi_in, .miso_in, .sck_in, .ss_in, .master_q, .data_rdata_q, .transfer_done_flag_q,
        .write_collision_flag_q, .busy_q, .mosi_out_q, .mosi_oe_q, .miso_out_q, .miso_oe_q,
        .sck_out_q, .sck_oe_q, .ss_out_q, .ss_oe_q);
    spmc_slave_model u_slv (.sck(sck_out_q), .ss_n(ss_out_q), .mosi(mosi_out_q),
        .lsb_first(bit_order_select), .tx(slv_tx), .miso(miso_in), .rx(slv_rx));
    initial forever #2 clk = ~clk;
    task end_sim;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task wr(input logic [7:0] b);
        @(negedge clk);
        data_wr = 1'h1;
        data_wdata = b;
        @(negedge clk);
        data_wr = 1'h0;
    endtask
    task clr;
        @(negedge clk);
        flag_clear = 1'h1;
        @(negedge clk);
        flag_clear = 1'h0;
    endtask
    // master byte: half period h, x adds a colliding write and a debug halt
    task mx(input logic [7:0] tx, input int h, input logic x);
        int n;
        wr(tx);
        n = 0;
        while (sck_out_q !== 1'h1 && n < 300) begin cyc(1); n++; end
        n = 0;
        while (sck_out_q === 1'h1 && n < 300) begin cyc(1); n++; end
        chk("sck_half", 8'(h), 8'(n));
        if (x) begin
            wr(8'hFF);
            chk("wcol", 8'h01, {7'h0, write_collision_flag_q});
            debug_halt = 1'h1;
            cyc(30);
            debug_halt = 1'h0;
        end
        n = 0;
        while ((transfer_done_flag_q !== 1'h1 || busy_q !== 1'h0) && n < 5000) begin
            cyc(1);
            n++;
        end
        chk("done", 8'h01, {7'h0, transfer_done_flag_q});
        chk("slave_rx", tx, slv_rx);
        clr;
        if (h >= 8) chk("master_rx", slv_tx, data_rdata_q);
    endtask
    // bench acts as master towards the core in slave mode
    task sx(input logic [7:0] b, input int nb, input logic [7:0] e);
        int i;
        logic [7:0] got;
        got = 8'h00;
        ss_in = 1'h0;
        cyc(8);
        chk("miso_oe_sel", 8'h01, {7'h0, miso_oe_q});
        for (i = 0; i < nb; i++) begin
            mosi_in = b[7 - i];
            cyc(6);
            sck_in = 1'h1;
            got = {got[6:0], miso_out_q};
            cyc(6);
            sck_in = 1'h0;
        end
        cyc(6);
        ss_in = 1'h1;
        cyc(8);
        chk("miso_oe_desel", 8'h00, {7'h0, miso_oe_q});
        chk("slave_done", {7'h0, nb == 8}, {7'h0, transfer_done_flag_q});
        if (nb == 8) chk("slave_miso", e, got);
        if (nb == 8) chk("slave_rdata", b, data_rdata_q);
    endtask
    initial begin
        #200000;
        mismatches++;
        end_sim;
    end
    initial begin
        cyc(5);
        rst_n = 1'h1;
        chk("reset", 8'h80, {ss_out_q, transfer_done_flag_q, write_collision_flag_q, master_q,
            mosi_oe_q, miso_oe_q, sck_oe_q, ss_oe_q});
        master_set = 1'h1;
        cyc(1);
        master_set = 1'h0;
        enable_bit = 1'h1;
        cyc(4);
        chk("master_oe", 8'h0B, {4'h0, mosi_oe_q, miso_oe_q, sck_oe_q, ss_oe_q});
        port_dir_out = 4'hE;
        cyc(3);
        chk("mosi_user", 8'h00, {7'h0, mosi_oe_q});
        port_dir_out = 4'hF;
        for (int f = 0; f < 4; f++) begin
            for (int d = 0; d < 2; d++) begin
                rate_divider_field = 2'(f);
                rate_double_bit = 1'(d);
                mx(8'hA5, (f == 3) ? 128 : 1 << (2 * f + 1 - d), 1'h0);
            end
        end
        rate_divider_field = 2'h1;
        rate_double_bit = 1'h0;
        for (int o = 0; o < 2; o++) begin
            bit_order_select = 1'(o);
            mx(8'hA5 ^ 8'(o * 8'h3F), 8, 1'(o));
        end
        bit_order_select = 1'h0;
        port_dir_out = 4'h7;
        select_pin_ignore_bit = 1'h1;
        ss_in = 1'h0;
        cyc(10);
        chk("ssd_master", 8'h01, {7'h0, master_q});
        select_pin_ignore_bit = 1'h0;
        cyc(10);
        chk("mm_loss", 8'h01, {6'h0, master_q, transfer_done_flag_q});
        ss_in = 1'h1;
        clr;
        port_dir_out = 4'hF;
        cyc(8);
        chk("slave_oe", 8'h00, {5'h0, mosi_oe_q, sck_oe_q, ss_oe_q});
        wr(8'hC3);
        sx(8'h96, 4, 8'hC3);
        wr(8'hC3);
        sx(8'h96, 8, 8'hC3);
        end_sim;
    end
endmodule
